// ### charger_i2c_register_slave_tb.sv
/*
  Self-checking bench of the serial register slave: buffered writes, reads,
  high-speed entry and foreign addresses through the master model.
  Assumes chg_link_master_model and the checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module charger_i2c_register_slave_tb;
  import chg_link_pkg::*;

  // --------------------------------------------------------------------------
  // signals, design, master, core model
  // --------------------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_ready = 1'b0;
  logic [7:0] mon_a = 8'hC3;
  logic [7:0] mon_b = 8'h3C;
  logic [7:0] rd_data;
  logic [7:0] rd_addr;
  logic scl, sda_low, sda_o, sda_oe, wr_valid, hs_mode, a;
  logic [7:0] d;
  wr_s wr_data;
  int bad_count = 0;
  int comparisons = 0;
  wire logic sda = !((sda_oe && !sda_o) || sda_low);

  always #2.5 clk = ~clk;

  chg_link_slave i_dut (.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .mon_a(mon_a), .mon_b(mon_b), .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .hs_mode(hs_mode));

  chg_link_master_model m (.scl(scl), .sda_low(sda_low), .sda(sda));

  // register core answers one clock after the offset
  always_ff @(posedge clk)
    rd_data <= rd_addr ^ 8'h5A;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // hang guard, about five times the expected run
  initial
  begin
    #400000;
    bad_count++;
    summarize();
  end

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    // pointer load, 33 bytes into a stalled 32-word buffer, pointer wraps
    m.start();
    m.wbyte(8'hD6, a);
    check(a, 0);
    m.wbyte(8'hF0, a);
    check(a, 0);
    for (int i = 0; i < 33; i++)
    begin
      m.wbyte(8'(i * 3 + 1), a);
      check(a, i == 32);
    end
    m.stop();
    for (int i = 0; i < 32; i++)
    begin
      @(posedge clk) #1;
      check(wr_valid, 1);
      check(wr_data, {8'(8'hF0 + i), 8'(i * 3 + 1)});
      wr_ready = 1'b1;
      @(posedge clk) #1 wr_ready = 1'b0;
    end
    repeat (3) @(posedge clk);
    #1;
    check(wr_valid, 0);
    // read at the kept pointer: both monitors live, then the core
    m.start();
    m.wbyte(8'hD7, a);
    check(a, 0);
    m.rbyte(1'b1, d);
    check(d, 8'hC3);
    m.rbyte(1'b1, d);
    check(d, 8'h3C);
    m.rbyte(1'b0, d);
    check(d, 8'h12 ^ 8'h5A);
    m.stop();
    // register address, repeated start, read form
    m.start();
    m.wbyte(8'hD6, a);
    m.wbyte(8'h11, a);
    check(a, 0);
    check(rd_addr, 8'h11);
    // monitor value moves before the repeated start: the read must see the new one
    @(posedge clk) #1 mon_b = 8'hA5;
    m.rstart();
    m.wbyte(8'hD7, a);
    m.rbyte(1'b0, d);
    check(d, 8'hA5);
    m.stop();
    // every high-speed master code
    for (int i = 8; i < 16; i++)
    begin
      m.start();
      m.wbyte(8'(i), a);
      check(a, 1);
      check(hs_mode, 0);
      m.rstart();
      check(hs_mode, 1);
      m.wbyte(8'hD6, a);
      check(a, 0);
      m.rstart();
      check(hs_mode, 1);
      m.stop();
      repeat (8) @(posedge clk);
      check(hs_mode, 0);
    end
    // foreign address, then own address inside the ignored frame
    m.start();
    m.wbyte(8'hA0, a);
    check(a, 1);
    m.wbyte(8'hD6, a);
    check(a, 1);
    m.stop();
    summarize();
  end
endmodule

`default_nettype wire

// ### chg_link_consts.svh
/*
  Constants for the charger serial register slave: slave address, high-speed
  master code, monitor register offsets and write buffer shape.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef CHG_LINK_CONSTS_SVH
`define CHG_LINK_CONSTS_SVH

// ----------------------------------------------------------------------------
// link addressing
// ----------------------------------------------------------------------------
`define SLAVE_ADDR7 7'h6B
`define SLAVE_ADDR_WR 8'hD6
`define HS_CODE_HI 5'h01
`define HS_CODE_MSB 7
`define HS_CODE_LSB 3

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define MON_A_OFFSET 8'h10
`define MON_B_OFFSET 8'h11
`define PTR_RESET 8'h00
`define PTR_STEP 8'h01

// ----------------------------------------------------------------------------
// bit counting and buffering
// ----------------------------------------------------------------------------
`define BITS_PER_BYTE 4'h8
`define MSB_POS 7
`define WR_FIFO_WIDTH 16
`define WR_FIFO_DEPTH 32

`endif

// ### chg_link_master_model.sv
/*
  Behavioural two-wire bus master: start, repeated start, stop, byte out, byte in.
  Assumes an open-drain data line with pull-up; scl stands high between frames.
*/
`timescale 1ns/1ps
`default_nettype none

module chg_link_master_model
(
  output var logic scl,
  output var logic sda_low,
  input wire logic sda
);
  // --------------------------------------------------------------------------
  // bus cycles, 125 ns clock period
  // --------------------------------------------------------------------------
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // one clock pulse; data set mid low phase, sampled at the rise
  task automatic bitx(input logic drv_low, output logic seen);
    #25 sda_low = drv_low;
    #37.5 scl = 1'b1;
    seen = sda;
    #62.5 scl = 1'b0;
  endtask

  // data falls while clock high
  task automatic start();
    sda_low = 1'b1;
    #62.5 scl = 1'b0;
  endtask

  task automatic rstart();
    #25 sda_low = 1'b0;
    #37.5 scl = 1'b1;
    #62.5 sda_low = 1'b1;
    #62.5 scl = 1'b0;
  endtask

  // data rises while clock high, both lines left high
  task automatic stop();
    #25 sda_low = 1'b1;
    #37.5 scl = 1'b1;
    #62.5 sda_low = 1'b0;
    #62.5;
  endtask

  // most significant bit first, then acknowledge slot released
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitx(!b[i], s);
    bitx(1'b0, ack);
  endtask

  task automatic rbyte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitx(1'b0, b[i]);
    bitx(mack, s);
    #25 sda_low = 1'b0;
  endtask
endmodule

`default_nettype wire

// ### chg_link_pkg.sv
/*
  Types shared by the charger serial register slave, its checker and its bench.
  Assumes chg_link_consts.svh is on the include path.
*/
`include "chg_link_consts.svh"

package chg_link_pkg;

  // ----------------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------------
  // one committed register write: target offset and value
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } wr_s;

  // link protocol position
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WDATA,
    ST_WACK,
    ST_RDATA,
    ST_RACK,
    ST_IGNORE
  } link_state_e;

endpackage

// ### chg_link_slave.sv
/*
  Two-wire serial register slave of the charger: address match, byte
  shifting, acknowledge, auto-incrementing pointer, high-speed entry and
  live monitor reads. Writes leave through a 32-word buffer.
  Assumes scl, sda and monitor inputs are asynchronous to clk; the register
  core answers rd_addr with rd_data on the next clk cycle.
*/
`timescale 1ns/1ps
`default_nettype none

`include "chg_link_consts.svh"

module chg_link_slave
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [7:0] mon_a,
  input wire logic [7:0] mon_b,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output chg_link_pkg::wr_s wr_data,
  output logic hs_mode
);

  import chg_link_pkg::*;

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic [7:0] mon_a_meta;
  logic [7:0] mon_a_live;
  logic [7:0] mon_b_meta;
  logic [7:0] mon_b_live;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  link_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic [7:0] ptr;
  logic ptr_loaded;
  logic hs_armed;
  logic push_valid;
  wr_s push_data;
  logic fifo_in_ready;
  logic byte_done;
  logic [7:0] read_value;

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  // pick the byte served for a register offset; monitors are live
  function automatic logic [7:0] read_mux(
    input logic [7:0] offset,
    input logic [7:0] live_a,
    input logic [7:0] live_b,
    input logic [7:0] core_data
  );
    logic [7:0] value;
    value = core_data;
    if (offset == `MON_A_OFFSET)
      value = live_a;
    else if (offset == `MON_B_OFFSET)
      value = live_b;
    return value;
  endfunction

  // pointer step with 8-bit wrap
  function automatic logic [7:0] ptr_next(input logic [7:0] p);
    return p + `PTR_STEP;
  endfunction

  // ----------------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------------
  // two flops per line, a third only for edge finding
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end
    else
    begin
      scl_sync <= {scl_sync[1:0], scl_i};
      sda_sync <= {sda_sync[1:0], sda_i};
    end
  end

  // monitor status lines: synchronised only, never filtered
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mon_a_meta <= 8'h00;
      mon_a_live <= 8'h00;
      mon_b_meta <= 8'h00;
      mon_b_live <= 8'h00;
    end
    else
    begin
      mon_a_meta <= mon_a;
      mon_a_live <= mon_a_meta;
      mon_b_meta <= mon_b;
      mon_b_live <= mon_b_meta;
    end
  end

  // ----------------------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------------------
  // edges use the second and third flops only
  assign scl_rise = scl_sync[1] && !scl_sync[2];
  assign scl_fall = !scl_sync[1] && scl_sync[2];
  assign start_seen = scl_sync[1] && scl_sync[2] && !sda_sync[1] && sda_sync[2];
  assign stop_seen = scl_sync[1] && scl_sync[2] && sda_sync[1] && !sda_sync[2];
  assign byte_done = (bit_cnt == `BITS_PER_BYTE);
  assign read_value = read_mux(ptr, mon_a_live, mon_b_live, rd_data);

  // ----------------------------------------------------------------------------
  // protocol sequencer
  // ----------------------------------------------------------------------------
  // a start always restarts address reception, from any state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state <= ST_IDLE;
    else if (stop_seen)
      state <= ST_IDLE;
    else if (start_seen)
      state <= ST_ADDR;
    else if (scl_fall)
    begin
      unique case (state)
        ST_IDLE:
          state <= ST_IDLE;
        ST_ADDR:
        begin
          if (byte_done)
          begin
            if (rx_shift[7:1] == `SLAVE_ADDR7)
              state <= ST_ADDR_ACK;
            else
              state <= ST_IGNORE;
          end
        end
        ST_ADDR_ACK:
          state <= rx_shift[0] ? ST_RDATA : ST_WDATA;
        ST_WDATA:
        begin
          if (byte_done)
            state <= ST_WACK;
        end
        ST_WACK:
          state <= sda_oe ? ST_WDATA : ST_IGNORE;
        ST_RDATA:
        begin
          if (byte_done)
            state <= ST_RACK;
        end
        ST_RACK:
          state <= rx_shift[0] ? ST_IGNORE : ST_RDATA;
        ST_IGNORE:
          state <= ST_IGNORE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // bit counter and receive shifter
  // ----------------------------------------------------------------------------
  // count clock rises within a byte, clear when the byte is closed
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bit_cnt <= 4'h0;
    else if (start_seen || stop_seen)
      bit_cnt <= 4'h0;
    else if (scl_fall && byte_done)
      bit_cnt <= 4'h0;
    else if (scl_rise && (state == ST_ADDR || state == ST_WDATA || state == ST_RDATA))
      bit_cnt <= bit_cnt + 4'h1;
  end

  // sample data on each rise, oldest bit ends at the top
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rx_shift <= 8'h00;
    else if (scl_rise)
    begin
      if (state == ST_ADDR || state == ST_WDATA)
        rx_shift <= {rx_shift[6:0], sda_sync[1]};
      else if (state == ST_RACK)
        rx_shift <= {7'h00, sda_sync[1]};
    end
  end

  // ----------------------------------------------------------------------------
  // high-speed mode
  // ----------------------------------------------------------------------------
  // code arms the switch, the next repeated start takes it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hs_armed <= 1'b0;
      hs_mode <= 1'b0;
    end
    else if (stop_seen)
    begin
      hs_armed <= 1'b0;
      hs_mode <= 1'b0;
    end
    else if (start_seen && hs_armed)
    begin
      hs_armed <= 1'b0;
      hs_mode <= 1'b1;
    end
    else if (scl_fall && state == ST_ADDR && byte_done
             && rx_shift[`HS_CODE_MSB:`HS_CODE_LSB] == `HS_CODE_HI)
      hs_armed <= 1'b1;
  end

  // ----------------------------------------------------------------------------
  // register pointer
  // ----------------------------------------------------------------------------
  // loaded by the first written byte, stepped per byte moved
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ptr <= `PTR_RESET;
      ptr_loaded <= 1'b0;
    end
    else if (start_seen)
      ptr_loaded <= 1'b0;
    else if (scl_fall && state == ST_WDATA && byte_done)
    begin
      if (!ptr_loaded)
      begin
        ptr <= rx_shift;
        ptr_loaded <= 1'b1;
      end
      else if (fifo_in_ready)
        ptr <= ptr_next(ptr);
    end
    else if (scl_fall && (state == ST_ADDR_ACK || state == ST_RACK) && tx_load_ok(state, rx_shift[0]))
      ptr <= ptr_next(ptr);
  end

  // true when a read byte is loaded on this falling edge
  function automatic logic tx_load_ok(input link_state_e st, input logic master_nack);
    logic ok;
    ok = 1'b0;
    if (st == ST_ADDR_ACK && rx_shift[0])
      ok = 1'b1;
    else if (st == ST_RACK && !master_nack)
      ok = 1'b1;
    return ok;
  endfunction

  // address for the register core follows the pointer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_addr <= `PTR_RESET;
    else
      rd_addr <= ptr;
  end

  // ----------------------------------------------------------------------------
  // write commit
  // ----------------------------------------------------------------------------
  // data bytes after the pointer byte go to the buffer one clock after the eighth fall
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      push_valid <= 1'b0;
      push_data <= '0;
    end
    else
    begin
      push_valid <= 1'b0;
      if (scl_fall && state == ST_WDATA && byte_done && ptr_loaded && fifo_in_ready)
      begin
        push_valid <= 1'b1;
        push_data.addr <= ptr;
        push_data.data <= rx_shift;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // transmit shifter
  // ----------------------------------------------------------------------------
  // load a byte when the master wants one, move out on each fall
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tx_shift <= 8'hFF;
    else if (scl_fall)
    begin
      if (tx_load_ok(state, rx_shift[0]))
        tx_shift <= read_value;
      else if (state == ST_RDATA)
        tx_shift <= {tx_shift[6:0], 1'b1};
    end
  end

  // ----------------------------------------------------------------------------
  // data line driver
  // ----------------------------------------------------------------------------
  // open drain: level is always low, only the enable moves
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sda_o <= 1'b0;
    else
      sda_o <= 1'b0;
  end

  // pull low for acknowledge or a zero read bit, release otherwise
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sda_oe <= 1'b0;
    else if (start_seen || stop_seen)
      sda_oe <= 1'b0;
    else if (scl_fall)
    begin
      sda_oe <= 1'b0;
      if (byte_done && state == ST_ADDR && rx_shift[7:1] == `SLAVE_ADDR7)
        sda_oe <= 1'b1;
      else if (byte_done && state == ST_WDATA && (!ptr_loaded || fifo_in_ready))
        sda_oe <= 1'b1;
      else if (tx_load_ok(state, rx_shift[0]))
        sda_oe <= !read_value[`MSB_POS];
      else if (state == ST_RDATA && !byte_done)
        sda_oe <= !tx_shift[`MSB_POS - 1];
    end
  end

  // ----------------------------------------------------------------------------
  // write buffer
  // ----------------------------------------------------------------------------
  // a full buffer refuses the byte with a not-acknowledge
  chg_wr_fifo #(
    .WIDTH(`WR_FIFO_WIDTH),
    .DEPTH(`WR_FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_data)
  );

endmodule

`default_nettype wire

// ### chg_link_slave_asserts.sv
/*
  Checker of the serial slave port as seen at its pins and buffer outputs.
  Assumes it is bound onto chg_link_slave; one clock domain, rst async high.
*/
`timescale 1ns/1ps
`default_nettype none

module chg_link_slave_checker
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic [7:0] mon_a,
  input wire logic [7:0] mon_b,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire chg_link_pkg::wr_s wr_data,
  input wire logic hs_mode
);
  import chg_link_pkg::*;

  // --------------------------------------------------------------------------
  // link and buffer properties
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // pin drive, timing of data changes, mode entry and exit, buffer handshake
  property p_drive_low; sda_o == 1'b0; endproperty
  a_drive_low: assert property (p_drive_low) else $error("data pin driven high");
  property p_oe_scl_low; $changed(sda_oe) |-> !scl_i; endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data drive changed with clock high");
  property p_oe_stands; $rose(sda_oe) |-> sda_oe [*8]; endproperty
  a_oe_stands: assert property (p_oe_stands) else $error("low drive released too early");
  property p_stop_hs; (scl_i && $rose(sda_i)) |-> ##[1:6] !hs_mode; endproperty
  a_stop_hs: assert property (p_stop_hs) else $error("high speed kept after stop");
  property p_hs_at_start; $rose(hs_mode) |-> scl_i && !sda_i; endproperty
  a_hs_at_start: assert property (p_hs_at_start) else $error("high speed entered outside start");
  property p_ptr_scl_low; $changed(rd_addr) |-> !scl_i; endproperty
  a_ptr_scl_low: assert property (p_ptr_scl_low) else $error("pointer moved with clock high");
  property p_pop_only; $fell(wr_valid) |-> $past(wr_ready); endproperty
  a_pop_only: assert property (p_pop_only) else $error("write lost without ready");
  property p_head_stable; wr_valid && !wr_ready |=> $stable(wr_data); endproperty
  a_head_stable: assert property (p_head_stable) else $error("buffer head changed while stalled");
  property p_valid_holds; wr_valid && !wr_ready |=> wr_valid; endproperty
  a_valid_holds: assert property (p_valid_holds) else $error("write valid dropped while stalled");
endmodule

bind chg_link_slave chg_link_slave_checker i_chk (.clk(clk), .rst(rst), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .mon_a(mon_a), .mon_b(mon_b), .rd_addr(rd_addr), .rd_data(rd_data),
  .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .hs_mode(hs_mode));

`default_nettype wire

// ### chg_wr_fifo.sv
/*
  Synchronous first-in first-out buffer with valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module chg_wr_fifo
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // ----------------------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------------------
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage, written only on push
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // pointers and fill level
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

endmodule

`default_nettype wire
